// ### logic/cfg_loader_map.svh
// ============================================================
// Constants for the EEPROM-to-port configuration mapper
// ============================================================
// Holds address, field, offset and reset macros for the mapper.
// Assumes it is included by its bare name by the decoder, merge and mapper files.
//
// What this block does
// RL1: EEPROM word bit 3 goes to config 144h bit 4 of that port.
// RL2: EEPROM bits 6:4 go to config CCh bits 26:24, logical port number.
// RL3: EEPROM bits 15:9 go to config 154h bits 7:1, VC0 traffic map.
// RL4: Power word bits 7:0 and 9:8 go to 214h bits 7:0 and 9:8.
// RL5: Power word bits 11:10 go to 214h bits 14:13, PM state.
// RL6: Power word bit 15 goes to 218h bit 0, system allocated.
// RL7: PM control bit 6 goes to 74h bit 14, Rx polarity disable.
// RL8: PM control bits 5:0 go to 74h bits 13:8.
// RL9: PM control bit 7 goes to 70h bit 31, VGA decode enable.
// RL10: PM control bits 15:8 go to 88h bits 31:24.
// RL11: Downstream ports 1-5: one word fills D4h bits 15:0.
// RL12: Downstream ports 1-5: a second word fills D4h bits 31:16.
// RL13: EEPROM word at B0h fills port 0 config 80h bits 15:0.
// RL14: Power words for ports 0-5 sit at 70h-7Ah, step two.
// RL15: PM control words for ports 0-5 sit at 80h-8Ah, step two.
// RL16: Slot high words at A2h-AAh; low words from 92h upward.
// RL17: Unmapped bits keep their value; only the named port changes.
`ifndef CFG_LOADER_MAP_SVH
`define CFG_LOADER_MAP_SVH

// ============================================================
// EEPROM word addresses
// ============================================================
`define EE_GEN_BASE 8'h60
`define EE_PWR_BASE 8'h70
`define EE_PMC_BASE 8'h80
`define EE_SLOT_LO_BASE 8'h92
`define EE_SLOT_HI_BASE 8'hA2
`define EE_PHY0_ADDR 8'hB0

// ============================================================
// Per-port config word index (offset in comment)
// ============================================================
`define CW_DECODE 4'h0
`define CW_PMCTL 4'h1
`define CW_PHY3 4'h2
`define CW_PHY5 4'h3
`define CW_LINKCAP 4'h4
`define CW_SLOTCAP 4'h5
`define CW_VCRES 4'h6
`define CW_VC0MAP 4'h7
`define CW_PBDATA 4'h8
`define CW_PBCAP 4'h9
`define CW_COUNT 10
`define CFG_RST 32'h0000_0000

// ============================================================
// Field positions: destination and EEPROM source
// ============================================================
`define F_LOWPRI_VC_DST 4
`define F_LOWPRI_VC_SRC 3
`define F_PORTNUM_DST 26:24
`define F_PORTNUM_SRC 6:4
`define F_VC0MAP_DST 7:1
`define F_VC0MAP_SRC 15:9
`define F_BASEPWR 7:0
`define F_SCALE 9:8
`define F_PMSTATE_DST 14:13
`define F_PMSTATE_SRC 11:10
`define F_SYSALLOC_DST 0
`define F_SYSALLOC_SRC 15
`define F_RXPOL_DST 14
`define F_RXPOL_SRC 6
`define F_PMCTL_DST 13:8
`define F_PMCTL_SRC 5:0
`define F_VGA_DST 31
`define F_VGA_SRC 7
`define F_PHY5_DST 31:24
`define F_PHY5_SRC 15:8
`define F_LOWORD 15:0
`define F_HIWORD 31:16

// ============================================================
// AXI4-Lite register map
// ============================================================
`define AX_CTRL 12'h000
`define AX_STATUS 12'h004
`define CFG_BANK_SEL 3'b010
`define CTRL_RST 32'h0000_0001
`define ST_FOREIGN 24
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ### logic/cfg_loader_pkg.sv
// ============================================================
// Types for the EEPROM-to-port configuration mapper
// ============================================================
// Holds the word kind enum and the config bank select struct.
// Assumes nothing of its surroundings.
package cfg_loader_pkg;

  // Kind of EEPROM word, from its address
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_GEN,
    KIND_PWR,
    KIND_PMC,
    KIND_SLOT_LO,
    KIND_SLOT_HI,
    KIND_PHY0
  } kind_t;

  // Decoded config bank address
  typedef struct packed {
    logic hit;
    logic [2:0] port;
    logic [3:0] word;
  } cfg_sel_t;

endpackage : cfg_loader_pkg

// ### logic/ee_word_decoder.sv
// ============================================================
// EEPROM word address decoder
// ============================================================
// Turns an EEPROM word address into a word kind and port index.
// Assumes the address comes from logic on the same clock.
`timescale 1ns/1ps
`include "cfg_loader_map.svh"

module ee_word_decoder #(
  parameter int NPORT = 6
) (
  // EEPROM word address
  input wire logic [7:0] i_addr,
  // Decoded kind and port
  output cfg_loader_pkg::kind_t o_kind,
  output logic [2:0] o_port
);
  import cfg_loader_pkg::*;

  // Address inside an even-stepped run of n words
  function automatic logic in_run(input logic [7:0] a,
                                  input logic [7:0] base,
                                  input int n);
    logic [7:0] d;
    d = a - base;
    return (a >= base) && (d < 8'(2 * n)) && !d[0];
  endfunction : in_run

  // Kind and port select
  always_comb begin
    o_kind = KIND_NONE;
    o_port = 3'h0;
    if (in_run(i_addr, `EE_GEN_BASE, NPORT)) begin
      o_kind = KIND_GEN;
      o_port = 3'((i_addr - `EE_GEN_BASE) >> 1);
    end else if (in_run(i_addr, `EE_PWR_BASE, NPORT)) begin
      o_kind = KIND_PWR; // RL14
      o_port = 3'((i_addr - `EE_PWR_BASE) >> 1);
    end else if (in_run(i_addr, `EE_PMC_BASE, NPORT)) begin
      o_kind = KIND_PMC; // RL15
      o_port = 3'((i_addr - `EE_PMC_BASE) >> 1);
    end else if (in_run(i_addr, `EE_SLOT_LO_BASE, NPORT - 1)) begin
      o_kind = KIND_SLOT_LO; // RL16
      o_port = 3'(((i_addr - `EE_SLOT_LO_BASE) >> 1) + 8'h01);
    end else if (in_run(i_addr, `EE_SLOT_HI_BASE, NPORT - 1)) begin
      o_kind = KIND_SLOT_HI; // RL16
      o_port = 3'(((i_addr - `EE_SLOT_HI_BASE) >> 1) + 8'h01);
    end else if (i_addr == `EE_PHY0_ADDR) begin
      o_kind = KIND_PHY0; // RL13
      o_port = 3'h0;
    end
  end

endmodule : ee_word_decoder

// ### logic/cfg_field_merge.sv
// ============================================================
// Field merge for one per-port config word
// ============================================================
// Places the fields of one EEPROM word into one config word.
// Assumes i_en is high only for the port the word names.
`timescale 1ns/1ps
`include "cfg_loader_map.svh"

module cfg_field_merge #(
  parameter logic [3:0] WORD_IDX = 4'h0
) (
  // EEPROM word and its kind
  input wire logic i_en,
  input cfg_loader_pkg::kind_t i_kind,
  input wire logic [15:0] i_data,
  // Config word before and after
  input wire logic [31:0] i_old,
  output logic [31:0] o_new
);
  import cfg_loader_pkg::*;

  // Only mapped bits move; the rest keep i_old
  always_comb begin
    o_new = i_old; // RL17
    if (i_en) begin
      case (i_kind)
        KIND_GEN: begin
          if (WORD_IDX == `CW_VCRES)
            o_new[`F_LOWPRI_VC_DST] = i_data[`F_LOWPRI_VC_SRC]; // RL1
          if (WORD_IDX == `CW_LINKCAP)
            o_new[`F_PORTNUM_DST] = i_data[`F_PORTNUM_SRC]; // RL2
          if (WORD_IDX == `CW_VC0MAP)
            o_new[`F_VC0MAP_DST] = i_data[`F_VC0MAP_SRC]; // RL3
        end
        KIND_PWR: begin
          if (WORD_IDX == `CW_PBDATA) begin
            o_new[`F_BASEPWR] = i_data[`F_BASEPWR]; // RL4
            o_new[`F_SCALE] = i_data[`F_SCALE]; // RL4
            o_new[`F_PMSTATE_DST] = i_data[`F_PMSTATE_SRC]; // RL5
          end
          if (WORD_IDX == `CW_PBCAP)
            o_new[`F_SYSALLOC_DST] = i_data[`F_SYSALLOC_SRC]; // RL6
        end
        KIND_PMC: begin
          if (WORD_IDX == `CW_PMCTL) begin
            o_new[`F_RXPOL_DST] = i_data[`F_RXPOL_SRC]; // RL7
            o_new[`F_PMCTL_DST] = i_data[`F_PMCTL_SRC]; // RL8
          end
          if (WORD_IDX == `CW_DECODE)
            o_new[`F_VGA_DST] = i_data[`F_VGA_SRC]; // RL9
          if (WORD_IDX == `CW_PHY5)
            o_new[`F_PHY5_DST] = i_data[`F_PHY5_SRC]; // RL10
        end
        KIND_SLOT_LO: begin
          if (WORD_IDX == `CW_SLOTCAP)
            o_new[`F_LOWORD] = i_data; // RL11
        end
        KIND_SLOT_HI: begin
          if (WORD_IDX == `CW_SLOTCAP)
            o_new[`F_HIWORD] = i_data; // RL12
        end
        KIND_PHY0: begin
          if (WORD_IDX == `CW_PHY3)
            o_new[`F_LOWORD] = i_data; // RL13
        end
        default: begin
          o_new = i_old;
        end
      endcase
    end
  end

endmodule : cfg_field_merge

// ### logic/eeprom_port_cfg_mapper.sv
// ============================================================
// EEPROM-to-port configuration mapper
// ============================================================
// Places EEPROM words into per-port config words, AXI4-Lite access.
// Assumes the EEPROM word stream comes from logic on i_mclk.
`timescale 1ns/1ps
`include "cfg_loader_map.svh"

module eeprom_port_cfg_mapper #(
  parameter int NPORT = 6
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // EEPROM word stream
  input wire logic i_ee_valid,
  input wire logic [7:0] i_ee_addr,
  input wire logic [15:0] i_ee_data,
  output logic o_ee_ready,
  // AXI4-Lite write address and data
  input wire logic [11:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Config words, port-major, word index minor
  output logic [NPORT*`CW_COUNT*32-1:0] o_cfg
);
  import cfg_loader_pkg::*;

  localparam int NW = `CW_COUNT;

  // ============================================================
  // Helpers
  // ============================================================
  // Byte-lane write of a 32-bit word
  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b])
        v[b*8 +: 8] = data[b*8 +: 8];
    end
    return v;
  endfunction : apply_strb

  // Config bank address decode
  function automatic cfg_sel_t cfg_decode(input logic [11:0] a);
    cfg_sel_t s;
    s.port = a[8:6];
    s.word = a[5:2];
    s.hit = (a[11:9] == `CFG_BANK_SEL) && (int'(s.port) < NPORT) &&
            (int'(s.word) < NW);
    return s;
  endfunction : cfg_decode

  // ============================================================
  // State
  // ============================================================
  logic [31:0] cfg [NPORT][NW];
  logic [31:0] base_cfg [NPORT][NW];
  logic [31:0] next_cfg [NPORT][NW];
  logic load_en;
  logic [15:0] st_count;
  logic [7:0] st_last;
  logic st_foreign;
  kind_t dec_kind;
  logic [2:0] dec_port;
  logic dec_hit;
  logic ee_take;
  logic aw_held;
  logic [11:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  cfg_sel_t wr_sel;
  cfg_sel_t rd_sel;
  logic wr_ok;
  logic [31:0] rd_word;
  logic rd_ok;

  // ============================================================
  // EEPROM word intake
  // ============================================================
  ee_word_decoder #(
    .NPORT(NPORT)
  ) u_dec (
    .i_addr(i_ee_addr),
    .o_kind(dec_kind),
    .o_port(dec_port)
  );

  // Stream stalls while loading is disabled
  assign o_ee_ready = load_en;
  assign ee_take = i_ee_valid && o_ee_ready;
  assign dec_hit = (dec_kind != KIND_NONE) && (int'(dec_port) < NPORT);

  // ============================================================
  // Config words: software write first, then EEPROM fields
  // ============================================================
  assign wr_sel = cfg_decode(aw_addr);

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    for (genvar k = 0; k < NW; k++) begin : g_word
      // Software write to this word
      assign base_cfg[p][k] =
        (do_write && wr_sel.hit && (int'(wr_sel.port) == p) &&
         (int'(wr_sel.word) == k)) ?
        apply_strb(cfg[p][k], w_data, w_strb) : cfg[p][k];
      cfg_field_merge #(
        .WORD_IDX(4'(k))
      ) u_merge (
        .i_en(ee_take && dec_hit && (int'(dec_port) == p)), // RL17
        .i_kind(dec_kind),
        .i_data(i_ee_data),
        .i_old(base_cfg[p][k]),
        .o_new(next_cfg[p][k])
      );
      assign o_cfg[(p*NW+k)*32 +: 32] = cfg[p][k];
    end
  end

  // Config word registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < NPORT; p++) begin
        for (int k = 0; k < NW; k++) begin
          cfg[p][k] <= `CFG_RST;
        end
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        for (int k = 0; k < NW; k++) begin
          cfg[p][k] <= next_cfg[p][k];
        end
      end
    end
  end

  // ============================================================
  // Control and status
  // ============================================================
  // Load enable bit
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_en <= 1'(`CTRL_RST);
    end else if (do_write && aw_addr == `AX_CTRL && w_strb[0]) begin
      load_en <= w_data[0];
    end
  end

  // Applied word count and last address
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_count <= 16'h0000;
      st_last <= 8'h00;
    end else if (ee_take && dec_hit) begin
      st_count <= st_count + 16'h0001;
      st_last <= i_ee_addr;
    end
  end

  // Foreign word flag, set wins over write-one clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_foreign <= 1'b0;
    end else if (ee_take && !dec_hit) begin
      st_foreign <= 1'b1;
    end else if (do_write && aw_addr == `AX_STATUS && w_strb[3] &&
                 w_data[`ST_FOREIGN]) begin
      st_foreign <= 1'b0;
    end
  end

  // ============================================================
  // AXI4-Lite write channel
  // ============================================================
  assign o_s_axi_awready = !aw_held;
  assign o_s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !o_s_axi_bvalid;
  assign wr_ok = wr_sel.hit || (aw_addr == `AX_CTRL) ||
                 (aw_addr == `AX_STATUS);

  // Address and data holding, either order
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `AXI_OKAY;
    end else if (do_write) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // ============================================================
  // AXI4-Lite read channel
  // ============================================================
  assign o_s_axi_arready = !o_s_axi_rvalid;
  assign rd_sel = cfg_decode(i_s_axi_araddr);

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rd_sel.hit) begin
      rd_word = cfg[rd_sel.port][rd_sel.word];
    end else if (i_s_axi_araddr == `AX_CTRL) begin
      rd_word = {31'h0000_0000, load_en};
    end else if (i_s_axi_araddr == `AX_STATUS) begin
      rd_word = {7'h00, st_foreign, st_last, st_count};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read data and response
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= `AXI_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_word;
      o_s_axi_rresp <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // ============================================================
  // Checks
  // ============================================================
  // Helper copy of the word taken last cycle
  logic q_take;
  kind_t q_kind;
  logic [2:0] q_port;
  logic [15:0] q_data;
  logic q_sw;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_take <= 1'b0;
      q_kind <= KIND_NONE;
      q_port <= 3'h0;
      q_data <= 16'h0000;
      q_sw <= 1'b0;
    end else begin
      q_take <= ee_take && dec_hit;
      q_kind <= dec_kind;
      q_port <= dec_port;
      q_data <= i_ee_data;
      q_sw <= do_write;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_gen;
    q_take && q_kind == KIND_GEN;
  endsequence
  sequence s_pwr;
    q_take && q_kind == KIND_PWR;
  endsequence
  sequence s_pmc;
    q_take && q_kind == KIND_PMC;
  endsequence

  property p_lowvc;
    s_gen |-> cfg[q_port][`CW_VCRES][`F_LOWPRI_VC_DST] ==
              q_data[`F_LOWPRI_VC_SRC];
  endproperty
  a_lowvc: assert property (p_lowvc) else $error("low vc bit"); // RL1

  property p_portnum;
    s_gen |-> cfg[q_port][`CW_LINKCAP][`F_PORTNUM_DST] ==
              q_data[`F_PORTNUM_SRC];
  endproperty
  a_portnum: assert property (p_portnum) else $error("port num"); // RL2

  property p_vc0map;
    s_gen |-> cfg[q_port][`CW_VC0MAP][`F_VC0MAP_DST] ==
              q_data[`F_VC0MAP_SRC];
  endproperty
  a_vc0map: assert property (p_vc0map) else $error("vc0 map"); // RL3

  property p_pwr;
    s_pwr |-> cfg[q_port][`CW_PBDATA][9:0] == q_data[9:0];
  endproperty
  a_pwr: assert property (p_pwr) else $error("power data"); // RL4

  property p_pmstate;
    s_pwr |-> cfg[q_port][`CW_PBDATA][`F_PMSTATE_DST] ==
              q_data[`F_PMSTATE_SRC];
  endproperty
  a_pmstate: assert property (p_pmstate) else $error("pm state"); // RL5

  property p_sysalloc;
    s_pwr |-> cfg[q_port][`CW_PBCAP][`F_SYSALLOC_DST] ==
              q_data[`F_SYSALLOC_SRC];
  endproperty
  a_sysalloc: assert property (p_sysalloc) else $error("sys alloc"); // RL6

  property p_pmctl;
    s_pmc |-> cfg[q_port][`CW_PMCTL][14:8] == q_data[6:0];
  endproperty
  a_pmctl: assert property (p_pmctl) else $error("pm control"); // RL7 RL8

  property p_vga;
    s_pmc |-> cfg[q_port][`CW_DECODE][`F_VGA_DST] == q_data[`F_VGA_SRC];
  endproperty
  a_vga: assert property (p_vga) else $error("vga enable"); // RL9

  property p_phy5;
    s_pmc |-> cfg[q_port][`CW_PHY5][`F_PHY5_DST] == q_data[`F_PHY5_SRC];
  endproperty
  a_phy5: assert property (p_phy5) else $error("phy ctl five"); // RL10

  property p_slot;
    q_take && q_kind inside {KIND_SLOT_LO, KIND_SLOT_HI} |->
      q_port != 3'h0 &&
      (q_kind == KIND_SLOT_LO ?
       cfg[q_port][`CW_SLOTCAP][`F_LOWORD] :
       cfg[q_port][`CW_SLOTCAP][`F_HIWORD]) == q_data;
  endproperty
  a_slot: assert property (p_slot) else $error("slot cap"); // RL11 RL12

  property p_phy0;
    q_take && q_kind == KIND_PHY0 |->
      q_port == 3'h0 && cfg[0][`CW_PHY3][`F_LOWORD] == q_data;
  endproperty
  a_phy0: assert property (p_phy0) else $error("phy ctl three"); // RL13

  property p_pwr_addr;
    ee_take && dec_kind == KIND_PWR |->
      i_ee_addr == `EE_PWR_BASE + 8'({dec_port, 1'b0});
  endproperty
  a_pwr_addr: assert property (p_pwr_addr) else $error("pwr addr"); // RL14

  property p_pmc_addr;
    ee_take && dec_kind == KIND_PMC |->
      i_ee_addr == `EE_PMC_BASE + 8'({dec_port, 1'b0});
  endproperty
  a_pmc_addr: assert property (p_pmc_addr) else $error("pmc addr"); // RL15

  property p_slot_addr;
    ee_take && dec_kind == KIND_SLOT_HI |->
      i_ee_addr == `EE_SLOT_HI_BASE + 8'({dec_port, 1'b0}) - 8'h02;
  endproperty
  a_slot_addr: assert property (p_slot_addr) else $error("slot addr"); // RL16

  property p_keep;
    q_take && q_port != 3'h0 && !q_sw |->
      cfg[0][`CW_PBDATA] == $past(cfg[0][`CW_PBDATA]) &&
      cfg[0][`CW_PMCTL] == $past(cfg[0][`CW_PMCTL]);
  endproperty
  a_keep: assert property (p_keep) else $error("other port hit"); // RL17

endmodule : eeprom_port_cfg_mapper

// ### testbench/ee_image_model.sv
// EEPROM image model: serves random 16-bit words on request.
// Assumes requests come just after rising edges of i_mclk.
`timescale 1ns/1ps
module ee_image_model (
  // Clock, reset and request
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [7:0] i_addr,
  input wire logic i_ready,
  // Word offered
  output logic o_valid,
  output logic [7:0] o_addr,
  output logic [15:0] o_data,
  output logic o_busy
);
  logic [15:0] mem [256];
  int seed;
  int wait_n;
  // Random image
  initial begin
    seed = 32'hBE80;
    foreach (mem[i]) mem[i] = 16'($random(seed));
  end
  // Random stall, hold until taken, then scramble the lines
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_busy <= 1'b0;
      o_addr <= 8'hFF;
      o_data <= 16'hFFFF;
      wait_n <= 0;
    end else if (i_go) begin
      o_busy <= 1'b1;
      o_addr <= i_addr;
      o_data <= ~mem[i_addr];
      wait_n <= $random(seed) & 3;
    end else if (o_busy && !o_valid) begin
      if (wait_n == 0) begin
        o_valid <= 1'b1;
        o_data <= mem[o_addr];
      end else
        wait_n <= wait_n - 1;
    end else if (o_valid && i_ready) begin
      o_valid <= 1'b0;
      o_busy <= 1'b0;
      o_addr <= ~o_addr;
      o_data <= ~o_data;
    end
  end
endmodule : ee_image_model

// ### testbench/tb_eeprom_port_cfg_mapper.sv
// Bench: config preload over AXI, EEPROM stream, model compare.
// Assumes the mapper, its header and the EEPROM model.
`timescale 1ns/1ps
`include "cfg_loader_map.svh"
module tb_eeprom_port_cfg_mapper;
  logic mclk, rst_n, go, rdy, ev, busy;
  logic [7:0] ga, ea;
  logic [15:0] ed;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rd, got;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, awr, wr, bv, arr, rv;
  logic [1:0] br, rr, rs, ws;
  logic [1919:0] cfg;
  logic [31:0] cfgm [60];
  int bad_count, checks, seed, cyc;
  eeprom_port_cfg_mapper DUT (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_ee_valid(ev), .i_ee_addr(ea), .i_ee_data(ed), .o_ee_ready(rdy),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wr), .o_s_axi_bresp(br),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rready), .o_cfg(cfg));
  ee_image_model pm (.i_mclk(mclk), .i_rst_n(rst_n), .i_go(go),
    .i_addr(ga), .i_ready(rdy), .o_valid(ev), .o_addr(ea), .o_data(ed),
    .o_busy(busy));
  // ==========================================================
  // Clock and hang guard
  // ==========================================================
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miss("timeout");
      wrap_up();
    end
  end
  // ==========================================================
  // Tasks
  // ==========================================================
  task miss(input string s);
    bad_count++;
    $display("[FAIL] %0t %s", $time, s);
  endtask : miss
  task wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (checks > 0 && bad_count == 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ra, rw, rb;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge mclk);
      ra = awr;
      rw = wr;
      @(posedge mclk);
      if (ra) awvalid <= 0;
      if (rw) wvalid <= 0;
    end while (awvalid && !ra || wvalid && !rw);
    do begin
      @(negedge mclk);
      rb = bv;
      ws = br;
      @(posedge mclk);
    end while (!rb);
    bready <= 0;
  endtask : axw
  task axr(input logic [11:0] a);
    logic t;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge mclk);
      t = arr;
      @(posedge mclk);
    end while (!t);
    arvalid <= 0;
    do begin
      @(negedge mclk);
      t = rv;
      rs = rr;
      got = rd;
      @(posedge mclk);
    end while (!t);
    rready <= 0;
  endtask : axr
  // Reference placement of one EEPROM word
  task upd(input logic [7:0] a, input logic [15:0] d);
    int p;
    p = 10 * a[3:1];
    if (a >= 8'h60 && a <= 8'h6A) begin
      cfgm[p+6][4] = d[3];
      cfgm[p+4][26:24] = d[6:4];
      cfgm[p+7][7:1] = d[15:9];
    end else if (a >= 8'h70 && a <= 8'h7A) begin
      cfgm[p+8][9:0] = d[9:0];
      cfgm[p+8][14:13] = d[11:10];
      cfgm[p+9][0] = d[15];
    end else if (a >= 8'h80 && a <= 8'h8A) begin
      cfgm[p+1][14:8] = d[6:0];
      cfgm[p][31] = d[7];
      cfgm[p+3][31:24] = d[15:8];
    end else if (a >= 8'h92 && a <= 8'h9A) cfgm[p+5][15:0] = d;
    else if (a >= 8'hA2 && a <= 8'hAA) cfgm[p+5][31:16] = d;
    else if (a == 8'hB0) cfgm[2][15:0] = d;
  endtask : upd
  task put(input logic [7:0] a);
    @(posedge mclk);
    go <= 1;
    ga <= a;
    @(posedge mclk);
    go <= 0;
    do @(negedge mclk); while (busy);
    upd(a, pm.mem[a]);
    checks++;
    foreach (cfgm[i])
      if (cfg[i*32 +: 32] !== cfgm[i]) miss("config word differs");
  endtask : put
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {rst_n, go, ga, awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    seed = 32'hBE80;
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    for (int i = 0; i < 60; i++) begin
      cfgm[i] = $random(seed);
      axw(12'h400 + 12'((i / 10) * 64 + (i % 10) * 4), cfgm[i], 4'hF);
      checks++;
      if (ws !== `AXI_OKAY) miss("write response");
    end
    axr(12'h51C);
    checks++;
    if (got !== cfgm[47] || rs !== `AXI_OKAY) miss("readback");
    for (int p = 0; p < 6; p++) begin
      put(8'h60 + 8'(2 * p));
      put(8'h70 + 8'(2 * p));
      put(8'h80 + 8'(2 * p));
      if (p > 0) put(8'h90 + 8'(2 * p));
      if (p > 0) put(8'hA0 + 8'(2 * p));
    end
    put(8'hB0);
    put(8'h50);
    axr(`AX_STATUS);
    checks++;
    if (got !== 32'h01B0_001D) miss("status word");
    axw(`AX_STATUS, 32'h0100_0000, 4'h8);
    axr(`AX_STATUS);
    checks++;
    if (got !== 32'h00B0_001D) miss("foreign clear");
    axw(`AX_CTRL, 32'h0, 4'hF);
    @(negedge mclk);
    checks++;
    if (rdy !== 1'b0) miss("load not stopped");
    axw(`AX_CTRL, 32'h1, 4'hF);
    axr(12'h0FC);
    checks++;
    if (rs !== `AXI_SLVERR) miss("unmapped read");
    axw(12'h0F8, 32'h0, 4'hF);
    checks++;
    if (ws !== `AXI_SLVERR) miss("unmapped write");
    wrap_up();
  end
endmodule : tb_eeprom_port_cfg_mapper
